// [rtl/spi_eeprom_command_protect.sv]
// Command decoder, write latch, status word and block protection of a serial EEPROM.
// Assumes an SPI master in mode 0 or 3 on sck_i/cs_n_i/si_i and a free-running clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_command_protect
  import eeprom_pkg::*;
#(
  parameter int ADDR_W          = 11,
  parameter int WRITE_CYCLE_CNT = WRITE_CYCLE_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  input  wire logic wp_n_i,
  output var  logic so_o,
  output var  logic so_oe_o
);

  localparam int CNT_W = $clog2(WRITE_CYCLE_CNT + 1);

  function automatic logic is_protected(input logic [ADDR_W-1:0] addr,
                                        input logic [1:0]        bp);
    logic hit;
    hit = 1'b0;
    unique case (bp)
      BP_NONE:    hit = 1'b0;
      BP_QUARTER: hit = &addr[ADDR_W-1 -: 2];
      BP_HALF:    hit = addr[ADDR_W-1];
      BP_ALL:     hit = 1'b1;
    endcase
    return hit;
  endfunction : is_protected

  // Keeps the page bits of an address and replaces the slot inside the page.
  function automatic logic [ADDR_W-1:0] page_slot(input logic [ADDR_W-1:0] addr,
                                                  input logic [PAGE_W-1:0] slot);
    return {addr[ADDR_W-1:PAGE_W], slot};
  endfunction : page_slot

  ////////////////////////////////////////////////////////////////////////////////
  // Storage shared by both domains.
  // The array changes only at the start of a write cycle and the serial side refuses
  // array reads while busy, so the serial side never samples it while it moves.

  logic [7:0]        mem [2**ADDR_W];
  logic [7:0]        page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask;
  frame_t            frame;
  logic [7:0]        addr_hi;
  logic [ADDR_W-1:0] ptr;
  logic              fresh;
  logic              frame_tog;
  logic [7:0]        shreg;
  logic [7:0]        status_meta;
  logic [7:0]        status_s;
  logic              read_refused;
  wr_state_t         state;
  logic              write_latch_flag;
  nv_status_t        nv;
  logic [CNT_W-1:0]  timer;

  wire logic       busy        = (state == W_PROG);
  wire logic [7:0] status_word = {nv.pin_en, 3'h0, nv.bp, write_latch_flag, busy};

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock domain: capture on rising edges.

  wire logic [7:0] shifted    = {shreg[6:0], si_i};
  wire logic [2:0] eff_bit    = fresh ? 3'h0 : frame.bit_idx;
  wire logic [2:0] eff_phase  = fresh ? PH_OPCODE : frame.phase;
  wire logic       byte_done  = (eff_bit == LAST_BIT);
  wire logic [15:0] full_addr = {addr_hi, shifted};
  wire logic [ADDR_W-1:0] next_ptr_wr =
    page_slot(ptr, ptr[PAGE_W-1:0] + 4'h1);
  wire logic [ADDR_W-1:0] next_ptr_rd = ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire logic is_write = (frame.opcode == OP_ARRAY_WRITE);
  wire logic is_read  = (frame.opcode == OP_ARRAY_READ);

  // Set by the select pin itself, so a new frame is recognised without a serial edge.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Each status bit is quasi-static, so a two-flop pass per bit is enough; a bit that
  // has just changed may show its old value for two serial clocks within a status read.
  always_ff @(posedge sck_i) begin
    status_meta <= status_word;
    status_s    <= status_meta;
  end

  wire logic       opcode_done  = byte_done && (eff_phase == PH_OPCODE);
  wire logic       addr_hi_done = byte_done && (eff_phase == PH_ADDR_HI);
  wire logic       addr_lo_done = byte_done && (eff_phase == PH_ADDR_LO);
  wire logic       data_done    = byte_done && (eff_phase == PH_DATA);
  wire logic       wr_byte      = data_done && is_write;
  wire logic       rd_byte      = data_done && is_read;
  wire logic [2:0] next_phase   =
    (eff_phase == PH_DATA) ? PH_DATA : eff_phase + 3'h1;
  wire logic [4:0] next_data_cnt =
    (frame.data_cnt == CNT_MAX) ? CNT_MAX : frame.data_cnt + 5'h01;

  // The frame marker needs a known start or no command is ever recognised.
  // The serial clock stands still during reset, so its release cannot race an edge.
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      frame_tog <= 1'b0;
    end else if (fresh) begin
      frame_tog <= ~frame_tog;
    end
  end

  always_ff @(posedge sck_i) begin
    shreg <= shifted;
  end

  always_ff @(posedge sck_i) begin
    frame.bit_idx <= eff_bit + 3'h1;
    if (fresh) begin
      frame.phase <= PH_OPCODE;
    end else if (byte_done) begin
      frame.phase <= next_phase;
    end
    if (opcode_done) begin
      frame.opcode   <= shifted;
      frame.data_cnt <= 5'h00;
    end else if (wr_byte) begin
      frame.data_cnt <= next_data_cnt;
    end
  end

  always_ff @(posedge sck_i) begin
    if (addr_hi_done) begin
      addr_hi <= shifted;
    end
  end

  always_ff @(posedge sck_i) begin
    if (addr_lo_done) begin
      ptr          <= full_addr[ADDR_W-1:0];
      read_refused <= status_s[ST_BUSY];
    end else if (wr_byte) begin
      ptr <= next_ptr_wr;
    end else if (rd_byte) begin
      ptr <= next_ptr_rd;
    end
  end

  always_ff @(posedge sck_i) begin
    if (opcode_done) begin
      page_mask <= '0;
    end else if (wr_byte) begin
      page_mask[ptr[PAGE_W-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge sck_i) begin
    if (wr_byte) begin
      page_buf[ptr[PAGE_W-1:0]] <= shifted;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock domain: drive on falling edges, released while deselected.

  wire logic talk_status = (frame.opcode == OP_STATUS_READ) && (frame.phase != PH_OPCODE);
  wire logic talk_array  = is_read && (frame.phase == PH_DATA) && !read_refused;
  wire logic [7:0] out_byte = talk_status ? status_s : mem[ptr];
  wire logic [2:0] out_idx  = LAST_BIT - frame.bit_idx;
  wire logic       next_so_oe = !fresh && (talk_status || talk_array);
  wire logic       next_so    = out_byte[out_idx];

  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_oe_o <= 1'b0;
      so_o    <= 1'b0;
    end else begin
      so_oe_o <= next_so_oe;
      so_o    <= next_so;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System clock domain: synchronisers.

  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic wp_meta;
  logic wp_sync;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;

  // The select pin gets a third flop so that its rise can be seen as an edge.
  always_ff @(posedge clk_sys_i) begin
    cs_meta <= cs_n_i;
    cs_sync <= cs_meta;
    cs_prev <= cs_sync;
  end

  always_ff @(posedge clk_sys_i) begin
    wp_meta <= wp_n_i;
    wp_sync <= wp_meta;
  end

  // The marker toggles once per frame, long before the select rise is seen here.
  always_ff @(posedge clk_sys_i) begin
    tog_meta <= frame_tog;
    tog_sync <= tog_meta;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System clock domain: command execution at the select rise.
  // The serial clock is idle while select is high, so the frame registers are static
  // by the time the synchronised rise is seen here.

  wire logic cs_rise    = cs_sync && !cs_prev;
  wire logic new_frame  = cs_rise && (tog_sync != tog_seen);
  wire logic whole      = (frame.bit_idx == 3'h0);
  wire logic hw_protect = nv.pin_en && !wp_sync;
  wire logic at_byte    = new_frame && whole;

  // A frame is judged by how many whole bytes it carried before the select rise.
  wire logic one_byte  = at_byte && (frame.phase == PH_ADDR_HI);
  wire logic two_bytes = at_byte && (frame.phase == PH_ADDR_LO);
  wire logic with_data = at_byte && (frame.phase == PH_DATA) && (frame.data_cnt != 5'h00);
  wire logic status_ok = write_latch_flag && !hw_protect && !busy;
  wire logic array_ok  = write_latch_flag && !busy && !is_protected(ptr, nv.bp);

  wire logic do_set      = one_byte && (frame.opcode == OP_LATCH_SET);
  wire logic do_clear    = one_byte && (frame.opcode == OP_LATCH_CLEAR);
  wire logic do_status   = two_bytes && (frame.opcode == OP_STATUS_WRITE) && status_ok;
  wire logic do_array    = with_data && is_write && array_ok;
  wire logic start_cycle = do_status || do_array;
  wire logic cycle_end   = busy && (timer == '0);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tog_seen <= 1'b0;
    end else if (cs_rise) begin
      tog_seen <= tog_sync;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= W_IDLE;
    end else begin
      unique case (state)
        W_IDLE: begin
          if (start_cycle) begin
            state <= W_PROG;
          end
        end
        W_PROG: begin
          if (cycle_end) begin
            state <= W_IDLE;
          end
        end
      endcase
    end
  end

  // The select rise can load the timer only from idle, so a started cycle always runs out.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer <= '0;
    end else if (start_cycle) begin
      timer <= CNT_W'(WRITE_CYCLE_CNT - 1);
    end else if (busy && !cycle_end) begin
      timer <= timer - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // A latch-set that lands on the cycle end wins over the clear.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      write_latch_flag <= LATCH_RESET;
    end else if (do_set) begin
      write_latch_flag <= 1'b1;
    end else if (do_clear || cycle_end) begin
      write_latch_flag <= 1'b0;
    end
  end

  // Nonvolatile bits keep their value only while powered here; reset restores them.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nv.pin_en <= PIN_EN_RESET;
      nv.bp     <= BP_RESET;
    end else if (do_status) begin
      nv.pin_en <= addr_hi[ST_PIN_EN];
      nv.bp     <= addr_hi[ST_BP_HI:ST_BP_LO];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (do_array) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_mask[i]) begin
          mem[page_slot(ptr, PAGE_W'(i))] <= page_buf[i];
        end
      end
    end
  end

endmodule : spi_eeprom_command_protect

`default_nettype wire

// [inc/eeprom_pkg.sv]
// Constants, field layouts and carrier types for the serial EEPROM command block.
// Assumes a 20 MHz system clock and an SPI master that drives the serial clock.
package eeprom_pkg;

  // Opcodes, sent most significant bit first.
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;

  // Field positions of status_word.
  localparam int ST_PIN_EN  = 7;
  localparam int ST_BP_HI   = 3;
  localparam int ST_BP_LO   = 2;
  localparam int ST_LATCH   = 1;
  localparam int ST_BUSY    = 0;

  // Block-protect encodings.
  localparam logic [1:0] BP_NONE    = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;
  localparam logic [1:0] BP_ALL     = 2'h3;

  // Reset values of the nonvolatile bits and of the write latch.
  localparam logic       PIN_EN_RESET = 1'h0;
  localparam logic [1:0] BP_RESET     = 2'h0;
  localparam logic       LATCH_RESET  = 1'h0;

  // Byte phases within one selected frame.
  localparam logic [2:0] PH_OPCODE  = 3'h0;
  localparam logic [2:0] PH_ADDR_HI = 3'h1;
  localparam logic [2:0] PH_ADDR_LO = 3'h2;
  localparam logic [2:0] PH_DATA    = 3'h3;

  localparam int         PAGE_BYTES  = 16;
  localparam int         PAGE_W      = 4;
  localparam logic [2:0] LAST_BIT    = 3'h7;
  localparam logic [4:0] CNT_MAX     = 5'h1F;

  // Internal write cycle time.
  localparam int CLK_SYS_HZ      = 20_000_000;
  localparam int WRITE_CYCLE_MS  = 5;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * (CLK_SYS_HZ / 1000);

  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] phase;
    logic [2:0] bit_idx;
    logic [4:0] data_cnt;
  } frame_t;

  typedef struct packed {
    logic       pin_en;
    logic [1:0] bp;
  } nv_status_t;

  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_PROG = 2'b10
  } wr_state_t;

endpackage : eeprom_pkg

// [sim/spi_host_model.sv]
// Host model that drives the serial link of the EEPROM block in mode 0.
// Assumes the bench calls its tasks one at a time; sck stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output var  logic sck_o,
  output var  logic cs_n_o,
  output var  logic si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  logic last = 1'b0;
  // A released output shows the inverse of its last value, never a kept level.
  wire  so_w = so_oe_i ? so_i : ~last;

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  ////////////////////////////////////////
  task automatic sel();
    cs_n_o = 1'b0;
    #10;
  endtask : sel

  task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si_o = b[i];
      #6 sck_o = 1'b1;
      r[i] = so_w;
      if (so_oe_i) last = so_i;
      #6 sck_o = 1'b0;
    end
  endtask : xfer

  // The long gap lets the system side see the deselect before the next frame.
  task automatic desel();
    #6 cs_n_o = 1'b1;
    si_o = ~si_o;
    #400;
  endtask : desel
endmodule : spi_host_model
`default_nettype wire

// [sim/spi_eeprom_command_protect_monitor.sv]
// Checker on the serial pins of the EEPROM command block.
// Assumes it is bound to the block's top and sck moves only while selected.
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_command_protect_monitor
  import eeprom_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic so_o,
  input wire logic so_oe_o
);
  logic [5:0] cnt;
  logic [7:0] op;
  wire        stat = (op == OP_STATUS_READ);

  // The count saturates so that long reads never alias the opcode window.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt <= 6'h00;
      op <= 8'h00;
    end else begin
      cnt <= (cnt == 6'h3F) ? cnt : cnt + 6'h01;
      op <= (cnt < 6'h08) ? {op[6:0], si_i} : op;
    end
  end
  ////////////////////////////////////////
  property p_release;
    @(posedge clk_sys_i) disable iff (rst_i) $rose(cs_n_i) |-> !so_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("output kept after deselect");
  property p_idle;
    @(posedge clk_sys_i) disable iff (rst_i) cs_n_i [*2] |-> !so_o && !so_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("output active while idle");
  property p_reset;
    @(posedge clk_sys_i) disable iff (rst_i) $fell(rst_i) |-> !so_oe_o [*4];
  endproperty
  a_reset: assert property (p_reset) else $error("output active after reset");
  property p_stat_drive;
    @(posedge sck_i) disable iff (rst_i || cs_n_i) stat && cnt >= 6'h08 |-> so_oe_o;
  endproperty
  a_stat_drive: assert property (p_stat_drive) else $error("status not driven");
  property p_stat_dc;
    @(posedge sck_i) disable iff (rst_i || cs_n_i) stat && cnt inside {[9:11]} |-> !so_o;
  endproperty
  a_stat_dc: assert property (p_stat_dc) else $error("status spare bit set");
  property p_other_quiet;
    @(posedge sck_i) disable iff (rst_i || cs_n_i)
      cnt >= 6'h08 && !stat && op != OP_ARRAY_READ |-> !so_oe_o;
  endproperty
  a_other_quiet: assert property (p_other_quiet) else $error("output on write");
  property p_addr_quiet;
    @(posedge sck_i) disable iff (rst_i || cs_n_i)
      op == OP_ARRAY_READ && cnt inside {[8:23]} |-> !so_oe_o;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("output during address");
  property p_op_quiet;
    @(posedge sck_i) disable iff (rst_i || cs_n_i) cnt < 6'h08 |-> !so_oe_o;
  endproperty
  a_op_quiet: assert property (p_op_quiet) else $error("output during opcode");
  c_stat: cover property (@(posedge sck_i) disable iff (cs_n_i) stat && cnt == 6'h18);
  c_read: cover property (@(posedge sck_i) disable iff (cs_n_i) cnt == 6'h19 && so_oe_o);
  c_write: cover property (@(posedge sck_i) disable iff (cs_n_i) op == OP_ARRAY_WRITE && cnt == 6'h20);
endmodule : spi_eeprom_command_protect_monitor

bind spi_eeprom_command_protect spi_eeprom_command_protect_monitor i_mon (
  .clk_sys_i, .rst_i, .sck_i, .cs_n_i, .si_i, .wp_n_i, .so_o, .so_oe_o
);
`default_nettype wire

// [sim/spi_eeprom_command_protect_tb_top.sv]
// Bench for the EEPROM command block: latch, random page writes, protection, status.
// Assumes the host model beside it and a shortened internal write cycle.
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_command_protect_tb_top
  import eeprom_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wp_n_i = 1'b1;
  wire logic   sck, cs_n, si, so, so_oe;
  logic [31:0] seed = 32'h0000680D;
  int          miscompares = 0;
  int          compares = 0;
  logic [7:0]  mem [1024];
  logic        pe, wl;
  logic [1:0]  bp;

  always #25 clk_sys_i = ~clk_sys_i;
  spi_eeprom_command_protect #(.ADDR_W(10), .WRITE_CYCLE_CNT(20)) i_dut (.clk_sys_i, .rst_i,
    .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .wp_n_i, .so_o(so), .so_oe_o(so_oe));
  spi_host_model i_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic prot(input logic [9:0] a);
    return bp == BP_ALL || (bp == BP_HALF && a[9]) || (bp == BP_QUARTER && a[9:8] == 2'h3);
  endfunction : prot
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic hdr(input logic [7:0] c, input logic [15:0] a);
    logic [7:0] r;
    i_host.sel();
    i_host.xfer(c, 8, r);
    i_host.xfer(a[15:8], 8, r);
    i_host.xfer(a[7:0], 8, r);
  endtask : hdr
  task automatic status_read_cmd(output logic [7:0] s);
    i_host.sel();
    i_host.xfer(OP_STATUS_READ, 8, s);
    i_host.xfer(8'h00, 8, s);
    i_host.xfer(8'h00, 8, s);
    i_host.desel();
  endtask : status_read_cmd
  // The second status byte is used since the first may lag a fresh change.
  task automatic done(input logic ok);
    logic [7:0] s;
    status_read_cmd(s);
    check(s, {pe, 3'h0, bp, wl, ok});
    for (int i = 0; i < 10 && s[ST_BUSY]; i++) status_read_cmd(s);
    if (ok) wl = 1'b0;
    status_read_cmd(s);
    check(s, {pe, 3'h0, bp, wl, 1'b0});
  endtask : done
  task automatic latch(input logic v);
    logic [7:0] r;
    i_host.sel();
    i_host.xfer(v ? OP_LATCH_SET : OP_LATCH_CLEAR, 8, r);
    i_host.desel();
    wl = v;
    done(1'b0);
  endtask : latch
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$], input int nb);
    logic [7:0] r;
    logic ok;
    ok = wl && nb == 8 && !prot(a[9:0]);
    hdr(OP_ARRAY_WRITE, a);
    foreach (d[i]) begin
      i_host.xfer(d[i], (i == d.size() - 1) ? nb : 8, r);
      if (ok) mem[{a[9:4], 4'(a[3:0] + i)}] = d[i];
    end
    i_host.desel();
    done(ok);
  endtask : wr
  task automatic rd(input logic [15:0] a, input int n);
    logic [7:0] r;
    hdr(OP_ARRAY_READ, a);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(8'h00, 8, r);
      check(r, mem[10'(a[9:0] + i)]);
    end
    i_host.desel();
  endtask : rd
  task automatic status_write_cmd(input logic [7:0] v);
    logic [7:0] r;
    logic ok;
    latch(1'b1);
    ok = !(pe && !wp_n_i);
    i_host.sel();
    i_host.xfer(OP_STATUS_WRITE, 8, r);
    i_host.xfer(v, 8, r);
    i_host.desel();
    if (ok) {pe, bp} = {v[7], v[3:2]};
    done(ok);
  endtask : status_write_cmd
  ////////////////////////////////////////
  initial begin
    logic [15:0] a;
    logic [7:0] d[$];
    logic [7:0] r;
    logic [15:0] pa[4];
    {pe, bp, wl} = 4'h0;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    done(1'b0);
    latch(1'b1);
    latch(1'b0);
    hdr(8'hFF, 16'h0000);
    i_host.desel();
    done(1'b0);
    for (int k = 0; k < 8; k++) begin
      a = (k == 0) ? 16'hFFF0 : (k == 1) ? 16'h0400 : 16'(rnd());
      d = {};
      repeat (16) d.push_back(8'(rnd()));
      latch(1'b1);
      wr(a, d, 8);
      rd({a[15:4], 4'h0}, 16);
    end
    rd(16'h03FF, 2);
    wr(16'h0000, {8'h5A}, 8);
    latch(1'b1);
    wr(16'h0000, {8'hA5}, 4);
    latch(1'b0);
    hdr(OP_LATCH_SET, {OP_ARRAY_WRITE, 8'h00});
    i_host.xfer(8'h00, 8, r);
    i_host.xfer(8'h3C, 8, r);
    i_host.desel();
    done(1'b0);
    rd(16'h0000, 1);
    for (int b = 0; b < 4; b++) begin
      status_write_cmd(8'(b << 2));
      for (int j = 0; j < 4; j++) begin
        if (b == 0) pa[j] = {6'h00, 2'(j), 8'(rnd())};
        a = pa[j];
        latch(1'b1);
        wr(a, {8'(rnd())}, 8);
        rd(a, 1);
      end
    end
    status_write_cmd(8'h80);
    @(posedge clk_sys_i) wp_n_i <= 1'b0;
    status_write_cmd(8'h8C);
    wr(16'h0123, {8'h77}, 8);
    rd(16'h0123, 1);
    latch(1'b0);
    latch(1'b1);
    @(posedge clk_sys_i) wp_n_i <= 1'b1;
    status_write_cmd(8'h00);
    summarize();
  end

  initial begin
    #1_000_000;
    miscompares++;
    summarize();
  end
endmodule : spi_eeprom_command_protect_tb_top
`default_nettype wire
